// file: inc/hdu_defs.vh
// constants of the half-duplex uart: register map, fields, resets, timing
// assumes a 20 MHz clk and an AXI4-Lite master with an 8-bit byte address
// Operation
// - frame format 0..3 selects 7+1, 7+2, 8+1, 8+2 character and stop bits.
// - parity inserted unless disabled; kinds: fixed 0, fixed 1, odd, even.
// - odd or even parity counts ones over character plus parity bit.
// - break control forces every transmitted bit, start to stop, to zero.
// - separate overrun, parity and framing flags plus a summary error flag.
// - reception error flags change only when reception completes.
// - flags hold their values until the next reception completes.
// - overrun when a character completes before the buffer was read.
// - parity error on wrong fixed bit or wrong odd or even count.
// - framing error when an expected stop bit samples low.
// - break received when start through stop were all zero.
// - async mode always divides the serial clock by eight.
// - bit count and divide setting derive automatically from the mode.
// - baud rate is one over overflow period times two times eight.
// - the baud clock comes from the internal compare timer output.
// - a start edge in the completion cycle is missed.
// - data write launches a frame; reception is off while sending.
// - a start bit counts only when low beyond half a bit.
// - async mode select at one enables the uart.
// - the line is left high after transmission.
`ifndef HDU_DEFS_VH
`define HDU_DEFS_VH
// register byte offsets
`define HDU_OFF_CTRL    8'h00
`define HDU_OFF_FMT     8'h04
`define HDU_OFF_STAT    8'h08
`define HDU_OFF_DATA    8'h0c
`define HDU_OFF_CMP     8'h10
`define HDU_OFF_TMODE   8'h14
// control fields
`define HDU_CTRL_ASYNC  0
`define HDU_CTRL_STE    1
`define HDU_CTRL_CKM    2
// format fields
`define HDU_FMT_NPE     0
`define HDU_FMT_PM_LO   1
`define HDU_FMT_PM_HI   2
`define HDU_FMT_FM_LO   3
`define HDU_FMT_FM_HI   4
`define HDU_FMT_BRK     5
// status fields
`define HDU_ST_ORE      0
`define HDU_ST_PE       1
`define HDU_ST_FE       2
`define HDU_ST_ERR      3
`define HDU_ST_BRK      4
`define HDU_ST_FULL     5
`define HDU_ST_TXB      6
`define HDU_ST_RXB      7
// reset values
`define HDU_CTRL_RST    8'h00
`define HDU_FMT_RST     8'h00
`define HDU_CMP_RST     8'h00
`define HDU_TMODE_RST   8'h00
// parity kinds
`define HDU_PAR_ZERO    2'h0
`define HDU_PAR_ONE     2'h1
`define HDU_PAR_ODD     2'h2
`define HDU_PAR_EVEN    2'h3
// timing: timer overflows per bit is 2 x 8 = 16
`define HDU_SUB_LAST    4'hf
`define HDU_SUB_HALF    4'h7
// bus answers
`define HDU_RESP_OKAY   2'h0
`define HDU_RESP_SLVERR 2'h2
`endif

// file: logic/hdu_baud.v
// baud timer: prescaler plus compare counter, one tick per overflow
// assumes run is low whenever the uart is not in async mode
`timescale 1ns/1ns
module hdu_baud (
	input  wire       clk,
	input  wire       rst,
	input  wire       run,
	input  wire [7:0] compare,
	input  wire [1:0] prescale,
	output reg        tick
);
	reg  [3:0] pre_cnt;
	reg  [7:0] cnt;
	reg        pre_hit;

	// prescale 0: clk, 1: clk/4, other: clk/16
	always @* begin
		case (prescale)
			2'h0:    pre_hit = 1'b1;
			2'h1:    pre_hit = (pre_cnt[1:0] == 2'h3);
			default: pre_hit = (pre_cnt == 4'hf);
		endcase
	end

	// overflow period is (compare + 1) timer clocks
	always @(posedge clk) begin
		if (rst || !run) begin
			pre_cnt <= 4'h0;
			cnt     <= 8'h00;
			tick    <= 1'b0;
		end else begin
			pre_cnt <= pre_cnt + 4'h1;
			tick    <= 1'b0;
			if (pre_hit) begin
				if (cnt >= compare) begin
					cnt  <= 8'h00;
					tick <= 1'b1;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule // hdu_baud

// file: logic/hdu_uart.v
// half-duplex async serial interface with an AXI4-Lite register slave
// assumes rx_line is already synchronous to clk and idles high
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "hdu_defs.vh"
module hdu_uart (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        rx_line,
	output reg         tx_line,
	output reg         serial_done_irq
);
	localparam RX_IDLE  = 3'b001;
	localparam RX_START = 3'b010;
	localparam RX_DATA  = 3'b100;

	reg  [7:0]  serial_control_reg;
	reg  [7:0]  format_reg;
	reg  [7:0]  baud_timer_compare;
	reg  [7:0]  baud_timer_mode;
	reg  [7:0]  aw_q;
	reg  [7:0]  w_q;
	reg         w_lane0;
	reg         aw_have;
	reg         w_have;
	reg         tx_busy;
	reg  [11:0] tx_frame;
	reg  [3:0]  tx_left;
	reg  [3:0]  tx_sub;
	reg  [2:0]  rx_state;
	reg         rx_prev;
	reg  [3:0]  rx_sub;
	reg  [3:0]  rx_idx;
	reg  [11:0] rx_bits;
	reg  [7:0]  shift_buffer;
	reg         rx_full;
	reg         overrun_flag;
	reg         parity_error_flag;
	reg         framing_error_flag;
	reg         any_error_flag;
	reg         break_rx_flag;
	reg  [3:0]  frame_len;
	reg  [3:0]  n_char;
	reg  [11:0] next_tx_frame;
	reg  [7:0]  tx_char;
	reg         tx_par;
	reg  [11:0] rx_word;
	reg  [7:0]  rx_char;
	reg         rx_pbit;
	reg         rx_par_bad;
	reg         rx_stop_bad;
	reg  [3:0]  stop_pos;
	reg  [7:0]  rd_mux;
	reg         rd_ok;
	integer     i;
	wire        baud_tick;

	// control decode
	wire       async_mode_select = serial_control_reg[`HDU_CTRL_ASYNC];
	wire       parity_disable    = format_reg[`HDU_FMT_NPE];
	wire [1:0] parity_kind       = format_reg[`HDU_FMT_PM_HI:`HDU_FMT_PM_LO];
	wire       frame_format_hi   = format_reg[`HDU_FMT_FM_HI];
	wire       frame_format_lo   = format_reg[`HDU_FMT_FM_LO];
	wire       break_control     = format_reg[`HDU_FMT_BRK];
	wire       rx_busy           = (rx_state != RX_IDLE);

	// bus strobes
	wire wr_fire  = aw_have && w_have && !s_axi_bvalid;
	wire wr_en    = wr_fire && w_lane0;
	wire rd_fire  = s_axi_arvalid && s_axi_arready;
	wire rd_data  = rd_fire && (s_axi_araddr == `HDU_OFF_DATA);
	wire tx_go    = wr_en && (aw_q == `HDU_OFF_DATA) && async_mode_select && !tx_busy && !rx_busy;
	wire tx_fin   = tx_busy && baud_tick && (tx_sub == `HDU_SUB_LAST) && (tx_left == 4'h0);
	wire rx_fin   = (rx_state == RX_DATA) && baud_tick && (rx_sub == `HDU_SUB_LAST) &&
			(rx_idx == frame_len - 4'h1);

	// timer runs only in async mode; the clock select bit is not consulted
	hdu_baud u_baud (
		.clk      (clk),
		.rst      (rst),
		.run      (async_mode_select),
		.compare  (baud_timer_compare),
		.prescale (baud_timer_mode[1:0]),
		.tick     (baud_tick)
	);

	// bits after the start bit, derived from frame format and parity
	always @* begin
		n_char    = frame_format_hi ? 4'h8 : 4'h7;
		frame_len = n_char + {3'h0, ~parity_disable} + (frame_format_lo ? 4'h2 : 4'h1);
		stop_pos  = n_char + {3'h0, ~parity_disable};
	end

	// transmit frame image, lsb first, start bit in bit 0
	always @* begin
		tx_char = frame_format_hi ? w_q : {1'b0, w_q[6:0]};
		case (parity_kind)
			`HDU_PAR_ZERO: tx_par = 1'b0;
			`HDU_PAR_ONE:  tx_par = 1'b1;
			`HDU_PAR_ODD:  tx_par = ~(^tx_char);
			default:       tx_par = ^tx_char;
		endcase
		next_tx_frame = 12'hfff;
		next_tx_frame[0] = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			if (i < n_char) begin
				next_tx_frame[i + 1] = tx_char[i];
			end
		end
		if (!parity_disable) begin
			next_tx_frame[n_char + 4'h1] = tx_par;
		end
		if (break_control) begin
			next_tx_frame = 12'h000;
		end
	end

	// transmitter: each bit lasts 16 timer overflows
	always @(posedge clk) begin
		if (rst) begin
			tx_busy  <= 1'b0;
			tx_frame <= 12'hfff;
			tx_left  <= 4'h0;
			tx_sub   <= 4'h0;
			tx_line  <= 1'b1;
		end else if (tx_go) begin
			tx_busy  <= 1'b1;
			tx_frame <= next_tx_frame;
			tx_left  <= frame_len;
			tx_sub   <= 4'h0;
			tx_line  <= next_tx_frame[0];
		end else if (tx_busy && baud_tick) begin
			if (tx_sub == `HDU_SUB_LAST) begin
				tx_sub <= 4'h0;
				if (tx_left == 4'h0) begin
					tx_busy <= 1'b0;
					tx_line <= 1'b1;
				end else begin
					tx_frame <= {1'b1, tx_frame[11:1]};
					tx_line  <= tx_frame[1];
					tx_left  <= tx_left - 4'h1;
				end
			end else begin
				tx_sub <= tx_sub + 4'h1;
			end
		end
	end

	// received frame with the final sample merged in
	always @* begin
		rx_word = rx_bits;
		rx_word[rx_idx] = rx_line;
		rx_char = frame_format_hi ? rx_word[7:0] : {1'b0, rx_word[6:0]};
		rx_pbit = rx_word[n_char];
		case (parity_kind)
			`HDU_PAR_ZERO: rx_par_bad = rx_pbit;
			`HDU_PAR_ONE:  rx_par_bad = ~rx_pbit;
			`HDU_PAR_ODD:  rx_par_bad = ~(^rx_char ^ rx_pbit);
			default:       rx_par_bad = ^rx_char ^ rx_pbit;
		endcase
		if (parity_disable) begin
			rx_par_bad = 1'b0;
		end
		rx_stop_bad = ~rx_word[stop_pos];
		if (frame_format_lo && !rx_word[stop_pos + 4'h1]) begin
			rx_stop_bad = 1'b1;
		end
	end

	// receiver state machine and reception flags
	always @(posedge clk) begin
		if (rst) begin
			rx_state           <= RX_IDLE;
			rx_prev            <= 1'b1;
			rx_sub             <= 4'h0;
			rx_idx             <= 4'h0;
			rx_bits            <= 12'h000;
			shift_buffer       <= 8'h00;
			rx_full            <= 1'b0;
			overrun_flag       <= 1'b0;
			parity_error_flag  <= 1'b0;
			framing_error_flag <= 1'b0;
			any_error_flag     <= 1'b0;
			break_rx_flag      <= 1'b0;
		end else begin
			rx_prev <= rx_line;
			if (rd_data) begin
				rx_full <= 1'b0;
			end
			case (rx_state)
				RX_IDLE: begin
					// edges are seen only here, so one in the completion cycle is lost
					if (async_mode_select && !tx_busy && rx_prev && !rx_line) begin
						rx_state <= RX_START;
						rx_sub   <= 4'h0;
					end
				end
				RX_START: begin
					if (!async_mode_select || (baud_tick && rx_line)) begin
						rx_state <= RX_IDLE; // too short to be a start bit
					end else if (baud_tick) begin
						if (rx_sub == `HDU_SUB_HALF) begin
							rx_state <= RX_DATA;
							rx_sub   <= 4'h0;
							rx_idx   <= 4'h0;
							rx_bits  <= 12'h000;
						end else begin
							rx_sub <= rx_sub + 4'h1;
						end
					end
				end
				RX_DATA: begin
					if (!async_mode_select) begin
						rx_state <= RX_IDLE;
					end else if (baud_tick) begin
						if (rx_sub == `HDU_SUB_LAST) begin
							rx_sub <= 4'h0; // mid-bit sample
							rx_bits[rx_idx] <= rx_line;
							rx_idx <= rx_idx + 4'h1;
						end else begin
							rx_sub <= rx_sub + 4'h1;
						end
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
			// flags are renewed only here and hold otherwise
			if (rx_fin) begin
				rx_state           <= RX_IDLE;
				shift_buffer       <= rx_char;
				rx_full            <= 1'b1; // set wins over the read clear
				overrun_flag       <= rx_full;
				parity_error_flag  <= rx_par_bad;
				framing_error_flag <= rx_stop_bad;
				any_error_flag     <= rx_full | rx_par_bad | rx_stop_bad;
				break_rx_flag      <= ~(|rx_word);
			end
		end
	end

	// completion pulse for both directions
	always @(posedge clk) begin
		if (rst) begin
			serial_done_irq <= 1'b0;
		end else begin
			serial_done_irq <= tx_fin | rx_fin;
		end
	end

	// write channels: address and data taken in either order, answer after both
	always @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `HDU_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_q          <= 8'h00;
			w_q           <= 8'h00;
			w_lane0       <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q          <= s_axi_awaddr;
				aw_have       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q          <= s_axi_wdata[7:0];
				w_lane0      <= s_axi_wstrb[0];
				w_have       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_q)
					`HDU_OFF_CTRL, `HDU_OFF_FMT, `HDU_OFF_STAT,
					`HDU_OFF_DATA, `HDU_OFF_CMP, `HDU_OFF_TMODE: s_axi_bresp <= `HDU_RESP_OKAY;
					default: s_axi_bresp <= `HDU_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// software-written registers; status and data writes store nothing here
	always @(posedge clk) begin
		if (rst) begin
			serial_control_reg <= `HDU_CTRL_RST;
			format_reg         <= `HDU_FMT_RST;
			baud_timer_compare <= `HDU_CMP_RST;
			baud_timer_mode    <= `HDU_TMODE_RST;
		end else if (wr_en) begin
			case (aw_q)
				`HDU_OFF_CTRL:  serial_control_reg <= {5'h00, w_q[2:0]};
				`HDU_OFF_FMT:   format_reg         <= {2'h0, w_q[5:0]};
				`HDU_OFF_CMP:   baud_timer_compare <= w_q;
				`HDU_OFF_TMODE: baud_timer_mode    <= {6'h00, w_q[1:0]};
				default: begin
				end
			endcase
		end
	end

	// read decode
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`HDU_OFF_CTRL:  rd_mux = serial_control_reg;
			`HDU_OFF_FMT:   rd_mux = format_reg;
			`HDU_OFF_STAT:  rd_mux = {rx_busy, tx_busy, rx_full, break_rx_flag, any_error_flag,
						framing_error_flag, parity_error_flag, overrun_flag};
			`HDU_OFF_DATA:  rd_mux = shift_buffer;
			`HDU_OFF_CMP:   rd_mux = baud_timer_compare;
			`HDU_OFF_TMODE: rd_mux = baud_timer_mode;
			default: begin
				rd_mux = 8'h00;
				rd_ok  = 1'b0;
			end
		endcase
	end

	// read channel: answer one cycle after the address is taken
	always @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `HDU_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rd_mux};
				s_axi_rresp   <= rd_ok ? `HDU_RESP_OKAY : `HDU_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // hdu_uart

// file: testbench/hdu_sva.sv
// checker: bus answers and serial output timing of the uart
// assumes it is bound to hdu_uart and sees only its ports
`timescale 1ns/1ns
module hdu_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        tx_line,
	input wire logic        serial_done_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// serial line and completion pulse
	property p_tx_rst; $fell(rst) |-> tx_line; endproperty
	a_tx_rst: assert property (p_tx_rst) else $error("tx line low after reset");
	property p_irq; serial_done_irq |=> !serial_done_irq; endproperty
	a_irq: assert property (p_irq) else $error("completion pulse too long");
	property p_start; $fell(tx_line) |=> !tx_line [*8]; endproperty
	a_start: assert property (p_start) else $error("start bit too short");
	property p_rel; serial_done_irq |-> ##[0:3] tx_line; endproperty
	a_rel: assert property (p_rel) else $error("tx line not released high");
	// register bus answers
	property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_ar: assert property (p_ar) else $error("read not answered");
	property p_aw; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
	a_aw: assert property (p_aw) else $error("write not answered");
	property p_hold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_hold: assert property (p_hold) else $error("write taken during response");
	property p_rd; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp != 2'h1; endproperty
	a_rd: assert property (p_rd) else $error("bad read data upper bits");
	// main scenarios reached
	c_irq: cover property (serial_done_irq);
	c_tx: cover property ($fell(tx_line));
	c_wr: cover property (s_axi_bvalid);
endmodule // hdu_sva
bind hdu_uart hdu_sva i_sva (.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .tx_line(tx_line), .serial_done_irq(serial_done_irq));

// file: testbench/hdu_remote.sv
// remote serial transceiver facing the uart lines
// assumes a bit time of bt clocks; its line idles high
`timescale 1ns/1ns
module hdu_remote #(parameter int BT = 16) (
	input wire logic clk,
	input wire logic tx_line,
	output logic     rx_line
);
	initial rx_line = 1'b1;
	// send n bits lsb first, each bt clocks, then idle high two bits
	task automatic send(input logic [11:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			rx_line <= v[i];
			repeat (BT) @(posedge clk);
		end
		rx_line <= 1'b1;
		repeat (2 * BT) @(posedge clk);
	endtask
	// short low pulse that is no start bit
	task automatic glitch;
		rx_line <= 1'b0;
		repeat (4) @(posedge clk);
		rx_line <= 1'b1;
		repeat (BT) @(posedge clk);
	endtask
	// capture n bits from the falling start edge, mid-bit sampling
	task automatic rcv(input int n, output logic [11:0] v, output bit to);
		int k;
		v = '0;
		to = 1;
		for (k = 0; k < 4000; k++) begin
			@(posedge clk);
			if (tx_line === 1'b0) break;
		end
		if (k < 4000) begin
			to = 0;
			repeat (BT / 2) @(posedge clk);
			for (int i = 0; i < n; i++) begin
				if (i > 0) repeat (BT) @(posedge clk);
				v[i] = tx_line;
			end
		end
	endtask
endmodule // hdu_remote

// file: testbench/testbench.sv
// self-checking bench of the half-duplex uart
// assumes the remote model drives rx_line and reads tx_line
`timescale 1ns/1ns
module testbench;
	localparam int BT = 16;
	logic        clk = 0;
	logic        rst = 1;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        arvalid = 0;
	logic [31:0] wdata = 0;
	wire         awready, wready, bvalid, arready, rvalid, rx_line, tx_line, irq;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	int          fails = 0;
	int          tests_run = 0;
	// 20 mhz clock
	always #25 clk = ~clk;
	// design and far side
	hdu_uart i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .rx_line(rx_line), .tx_line(tx_line), .serial_done_irq(irq));
	hdu_remote #(.BT(BT)) i_rem (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
	task automatic results;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic to(input string nm);
		chk(nm, 0, 1);
		results();
	endtask
	// write with address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		bit pa;
		bit pw;
		pa = 1;
		pw = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (pa && awready) begin
				pa = 0;
				awvalid <= 0;
			end
			if (pw && wready) begin
				pw = 0;
				wvalid <= 0;
			end
			if (!pa && !pw && bvalid === 1'b1) break;
		end
		if (k == 100) to("write timeout");
		r = bresp;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		araddr <= a;
		arvalid <= 1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		if (k == 100) to("read timeout");
		d = rdata;
		r = rresp;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk("bresp", 2'h0, r);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk("rresp", 2'h0, r);
		chk(nm, e, d);
	endtask
	task automatic wait_irq;
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge clk);
			if (irq === 1'b1) break;
		end
		if (k == 3000) to("irq timeout");
	endtask
	// expected frame lsb first: start, chars, parity, stops
	function automatic logic [11:0] fr(input logic [7:0] d, input int nc, input int pm, input bit np,
		input int ns, output int n);
		logic p;
		fr = '0;
		p = 0;
		n = 1;
		for (int i = 0; i < nc; i++) begin
			fr[n] = d[i];
			p ^= d[i];
			n++;
		end
		if (!np) begin
			fr[n] = (pm == 0) ? 1'b0 : (pm == 1) ? 1'b1 : (pm == 2) ? ~p : p;
			n++;
		end
		for (int i = 0; i < ns; i++) begin
			fr[n] = 1'b1;
			n++;
		end
	endfunction
	// reset values, read-only status, unmapped place
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
		foreach (ad[i]) rdc("reset value", ad[i], 0);
		wr(8'h08, 8'hff);
		rdc("status ro", 8'h08, 0);
		axr(8'h18, d, r);
		chk("bad rresp", 2'h2, r);
		axw(8'h18, 1, r);
		chk("bad bresp", 2'h2, r);
		wr(8'h00, 8'h05);
		rdc("ctrl", 8'h00, 8'h05);
	endtask
	// every frame format and parity kind, then break
	task automatic t_tx;
		logic [11:0] e;
		logic [11:0] g;
		bit t;
		int n;
		logic [1:0] f;
		for (int c = 0; c < 6; c++) begin
			f = c % 4;
			e = fr(8'hb5, f[1] ? 8 : 7, f, c == 4, f[0] + 1, n);
			if (c == 5) e = '0;
			wr(8'h04, {2'h0, c == 5, f, f, c == 4});
			fork
				i_rem.rcv(n, g, t);
				begin
					wr(8'h0c, 8'hb5);
					rdc("tx busy", 8'h08, 8'h40);
				end
			join
			chk("tx timeout", 0, t);
			chk("tx frame", e, g);
			wait_irq();
		end
	endtask
	task automatic rxc(input logic [11:0] v, input logic [7:0] st, input logic [7:0] dt, input bit rd);
		logic [31:0] d;
		logic [1:0] r;
		fork
			i_rem.send(v, 11);
			wait_irq();
		join
		axr(8'h08, d, r);
		chk("status", st, d & 32'h3f);
		if (rd) rdc("rx data", 8'h0c, dt);
	endtask
	// receive: glitch, good, parity, framing, break, overrun
	task automatic t_rx;
		logic [11:0] v;
		int n;
		wr(8'h04, 8'h16);
		i_rem.glitch();
		rxc(fr(8'ha5, 8, 3, 0, 1, n), 8'h20, 8'ha5, 1);
		v = fr(8'h3c, 8, 3, 0, 1, n);
		v[9] = ~v[9];
		rxc(v, 8'h2a, 8'h3c, 1);
		v = fr(8'h0f, 8, 3, 0, 1, n);
		v[10] = 0;
		rxc(v, 8'h2c, 8'h0f, 1);
		rxc(12'h0, 8'h3c, 8'h00, 1);
		rxc(fr(8'h11, 8, 3, 0, 1, n), 8'h20, 8'h11, 0);
		rxc(fr(8'h22, 8, 3, 0, 1, n), 8'h29, 8'h22, 1);
		// seven bits, odd parity, two stop bits at both ends
		wr(8'h04, 8'h0c);
		rxc(fr(8'h35, 7, 2, 0, 2, n), 8'h20, 8'h35, 1);
		// sender adds a fixed-one parity bit, receiver runs without parity
		wr(8'h04, 8'h11);
		rxc(fr(8'h5a, 8, 1, 0, 1, n), 8'h20, 8'h5a, 1);
	endtask
	// reset for six cycles, then the scenarios
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_regs();
		t_tx();
		t_rx();
		results();
	end
endmodule // testbench
